// [src/tpv_arbiter.sv]
// Fixed priority arbiter that picks one pending condition and its vector.
`timescale 1ns/100ps
module tpv_arbiter (
    input  wire logic [9:0]  pending_in,   // Pending conditions, index 0 highest.
    input  wire logic [2:0]  priority_in,  // Processor priority from the status word.
    input  wire logic [15:0] irq_vec7_in,  // Device vector for level seven.
    input  wire logic [15:0] irq_vec6_in,  // Device vector for level six.
    input  wire logic [15:0] irq_vec5_in,  // Device vector for level five.
    input  wire logic [15:0] irq_vec4_in,  // Device vector for level four.
    output logic             any_out,      // One eligible condition exists.
    output logic [9:0]       grant_out,    // One-hot grant.
    output logic [15:0]      vector_out    // Vector of the granted condition.
);

    logic [9:0] eligible;  // Pending conditions after interrupt masking.

    // Levels n are blocked when the priority is n or higher; traps are never gated.
    always_comb begin
        eligible = pending_in;
        eligible[tpv_pkg::TPV_C_IRQ7] = pending_in[tpv_pkg::TPV_C_IRQ7] & (priority_in < 3'd7);
        eligible[tpv_pkg::TPV_C_IRQ6] = pending_in[tpv_pkg::TPV_C_IRQ6] & (priority_in < 3'd6);
        eligible[tpv_pkg::TPV_C_IRQ5] = pending_in[tpv_pkg::TPV_C_IRQ5] & (priority_in < 3'd5);
        eligible[tpv_pkg::TPV_C_IRQ4] = pending_in[tpv_pkg::TPV_C_IRQ4] & (priority_in < 3'd4);
    end

    // Lowest index wins; a scan from the bottom keeps the ranking in one place.
    always_comb begin
        grant_out = 10'h000;
        any_out   = 1'b0;
        for (int i = tpv_pkg::TPV_N_COND - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                grant_out = 10'h000;
                grant_out[i] = 1'b1;
                any_out = 1'b1;
            end
        end
    end

    // Each trap grant maps onto its fixed location; a level grant takes its device vector.
    always_comb begin
        unique case (1'b1)
            grant_out[tpv_pkg::TPV_C_MAP]:     vector_out = tpv_pkg::TPV_VEC_MAP;
            grant_out[tpv_pkg::TPV_C_TIMEOUT]: vector_out = tpv_pkg::TPV_VEC_TIMEOUT;
            grant_out[tpv_pkg::TPV_C_PARITY]:  vector_out = tpv_pkg::TPV_VEC_PARITY;
            grant_out[tpv_pkg::TPV_C_TRACE]:   vector_out = tpv_pkg::TPV_VEC_TRACE;
            grant_out[tpv_pkg::TPV_C_STACK]:   vector_out = tpv_pkg::TPV_VEC_STACK;
            grant_out[tpv_pkg::TPV_C_POWER]:   vector_out = tpv_pkg::TPV_VEC_POWER;
            grant_out[tpv_pkg::TPV_C_IRQ7]:    vector_out = irq_vec7_in;
            grant_out[tpv_pkg::TPV_C_IRQ6]:    vector_out = irq_vec6_in;
            grant_out[tpv_pkg::TPV_C_IRQ5]:    vector_out = irq_vec5_in;
            grant_out[tpv_pkg::TPV_C_IRQ4]:    vector_out = irq_vec4_in;
            default:                           vector_out = 16'h0000;  // No grant.
        endcase
    end

endmodule : tpv_arbiter

// [src/tpv_pkg.sv]
// Package of constants and types for the trap priority and vectoring unit.
package tpv_pkg;

    // APB register byte offsets.
    localparam logic [7:0] TPV_STATUS_OFF  = 8'h00;  // Sticky event flags, write one to clear.
    localparam logic [7:0] TPV_MASK_OFF    = 8'h04;  // Interrupt output mask.
    localparam logic [7:0] TPV_PSW_OFF     = 8'h08;  // Processor status word.
    localparam logic [7:0] TPV_SP_OFF      = 8'h0C;  // Kernel stack pointer.
    localparam logic [7:0] TPV_PC_OFF      = 8'h10;  // Program counter.
    localparam logic [7:0] TPV_CTRL_OFF    = 8'h14;  // Control strobes.
    localparam logic [7:0] TPV_VECTOR_OFF  = 8'h18;  // Last vector taken, read only.
    localparam logic [7:0] TPV_PEND_OFF    = 8'h1C;  // Pending conditions, read only.
    localparam logic [7:0] TPV_MEMADR_OFF  = 8'h20;  // Stack memory window address.
    localparam logic [7:0] TPV_MEMDAT_OFF  = 8'h24;  // Stack memory window data.

    // Control register bit positions.
    localparam int TPV_CTRL_END_BIT    = 0;  // End of instruction strobe.
    localparam int TPV_CTRL_RTI_BIT    = 1;  // Return from interrupt strobe.
    localparam int TPV_CTRL_JSR_BIT    = 2;  // Coroutine call strobe.
    localparam int TPV_CTRL_RESUME_BIT = 3;  // Leave console debug mode.

    // Pending vector indices, highest priority first.
    localparam int TPV_N_COND    = 10;
    localparam int TPV_C_MAP     = 0;
    localparam int TPV_C_TIMEOUT = 1;
    localparam int TPV_C_PARITY  = 2;
    localparam int TPV_C_TRACE   = 3;
    localparam int TPV_C_STACK   = 4;
    localparam int TPV_C_POWER   = 5;
    localparam int TPV_C_IRQ7    = 6;
    localparam int TPV_C_IRQ6    = 7;
    localparam int TPV_C_IRQ5    = 8;
    localparam int TPV_C_IRQ4    = 9;

    // Status word bit positions.
    localparam int TPV_PSW_TRACE_BIT = 4;
    localparam int TPV_PSW_PRI_LO    = 5;

    // Sticky status bits.
    localparam int TPV_ST_TRAP     = 0;  // A trap or interrupt was entered.
    localparam int TPV_ST_CONFLICT = 1;  // Two abort sources arrived together.
    localparam int TPV_ST_DEBUG    = 2;  // Console debug mode was entered.
    localparam int TPV_N_ST        = 3;

    // Fixed vector locations and the stack limit (octal).
    localparam logic [15:0] TPV_VEC_MAP     = 16'o250;
    localparam logic [15:0] TPV_VEC_TIMEOUT = 16'o4;
    localparam logic [15:0] TPV_VEC_PARITY  = 16'o114;
    localparam logic [15:0] TPV_VEC_TRACE   = 16'o14;
    localparam logic [15:0] TPV_VEC_STACK   = 16'o4;
    localparam logic [15:0] TPV_VEC_POWER   = 16'o24;
    localparam logic [15:0] TPV_STACK_LIMIT = 16'o400;

    // Reset values.
    localparam logic [15:0] TPV_SP_RESET  = 16'h0200;
    localparam logic [15:0] TPV_PSW_RESET = 16'h0000;
    localparam logic [15:0] TPV_PC_RESET  = 16'h0000;

    // Words of stack and vector memory.
    localparam int TPV_MEM_WORDS = 256;

    // Sequencer states.
    typedef enum logic [3:0] {
        TPV_IDLE,
        TPV_PUSH_PSW,
        TPV_PUSH_PC,
        TPV_LOAD_PC,
        TPV_LOAD_PSW,
        TPV_DEBUG,
        TPV_RTI_PC,
        TPV_RTI_PSW,
        TPV_JSR_POP,
        TPV_JSR_PUSH
    } tpv_state_t;

endpackage : tpv_pkg

// [src/tpv_top.sv]
// Trap and interrupt arbitration with vectoring, stack sequencing and an APB register file.
//
// Summary of operation
// - Service pending conditions in fixed priority order.
// - Trap enters service state, vectors to fixed location.
// - Mapping violation aborts, vectors to octal 250.
// - Bus timeout aborts, vectors to octal 4.
// - Parity error aborts, vectors to octal 114.
// - Trace bit at instruction end traps 14.
// - Kernel stack below 400 traps to 4.
// - Power loss during instruction traps to 24.
// - The six trap conditions are never maskable.
// - At most one abort condition pending together.
// - Coroutine call swaps PC with stack top.
// - Entry pushes status, PC; loads PC, status.
// - Priority bits 7 to 5 mask request levels.
// - Return pops PC then status word.
// - Halt request in service state enters debug.
`timescale 1ns/100ps
module tpv_top (
    input  wire logic        clock_in,          // 20 MHz processor clock.
    input  wire logic        rstn_in,           // Asynchronous active low reset.
    input  wire logic        psel_in,           // APB select.
    input  wire logic        penable_in,        // APB access phase.
    input  wire logic        pwrite_in,         // APB write.
    input  wire logic [7:0]  paddr_in,          // APB byte address.
    input  wire logic [31:0] pwdata_in,         // APB write data.
    output logic [31:0]      prdata_out,        // APB read data.
    output logic             pready_out,        // APB ready.
    output logic             pslverr_out,       // APB error for unmapped addresses.
    input  wire logic        mapping_violation_flag_in,  // Mapping violation from the translator.
    input  wire logic        bus_timeout_flag_in,        // No device answered.
    input  wire logic        bus_parity_flag_in,         // Parity error line from the bus.
    input  wire logic        control_fault_flag_in,      // Control fault from the sequencer.
    input  wire logic        power_good_in,     // Bus power good, high while power is fine.
    input  wire logic        irq_level_seven_in,
    input  wire logic        irq_level_six_in,
    input  wire logic        irq_level_five_in,
    input  wire logic        irq_level_four_in,
    input  wire logic [15:0] irq_vector_in,     // Vector word from the acknowledged device.
    input  wire logic        halt_request_in,   // Bus halt request, high when asserted.
    output logic [3:0]       irq_ack_out,       // Vector acknowledge, one bit per level seven to four.
    output logic             service_state_out, // High during the service sequence.
    output logic             console_debug_mode_out,  // High in console debug mode.
    output logic             irq_out            // Level interrupt from unmasked status.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers for bus pins.

    logic [9:0] pin_s1_q;  // First stage, read only by the second.
    logic [9:0] pin_s2_q;  // Second stage.
    logic       power_last_q;  // Power good of the previous cycle.

    // Two flops before any logic looks at a pin.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_s1_q     <= 10'h010;
            pin_s2_q     <= 10'h010;
            power_last_q <= 1'b1;
        end else begin
            pin_s1_q     <= {halt_request_in, irq_level_four_in, irq_level_five_in, irq_level_six_in,
                             irq_level_seven_in, power_good_in, control_fault_flag_in, bus_parity_flag_in,
                             bus_timeout_flag_in, mapping_violation_flag_in};
            pin_s2_q     <= pin_s1_q;
            power_last_q <= pin_s2_q[4];
        end
    end

    // Only the second stage is read from here on.
    logic       s_map;   // Abort sources.
    logic       s_tmo;
    logic       s_par;
    logic       s_ctl;
    logic       s_pwr;   // Power good.
    logic       s_halt;  // Halt request.
    logic [3:0] s_irq;   // Bit 0 level seven, bit 3 level four.
    assign s_map  = pin_s2_q[0];
    assign s_tmo  = pin_s2_q[1];
    assign s_par  = pin_s2_q[2];
    assign s_ctl  = pin_s2_q[3];
    assign s_pwr  = pin_s2_q[4];
    assign s_irq  = pin_s2_q[8:5];
    assign s_halt = pin_s2_q[9];

    ////////////////////////////////////////////////////////////////////////////////
    // Processor state and stack memory.

    tpv_pkg::tpv_state_t state_q;  // Sequencer state.
    logic [15:0] psw_q;            // Processor status word.
    logic [15:0] sp_q;             // Kernel stack pointer.
    logic [15:0] pc_q;             // Program counter.
    logic [15:0] tmp_q;            // Popped word or chosen vector.
    logic [15:0] vector_q;         // Last vector taken.
    logic [15:0] mem_q [tpv_pkg::TPV_MEM_WORDS];  // Stack and vector words.
    logic [2:0]  status_q;         // Sticky event flags.
    logic [2:0]  mask_q;           // Interrupt mask.
    logic [7:0]  memadr_q;         // Memory window word address.
    logic [5:0]  trap_pend_q;      // Latched trap conditions.

    // Word index of a byte address within the memory.
    function automatic logic [7:0] tpv_widx(input logic [15:0] byte_addr);
        tpv_widx = byte_addr[8:1];
    endfunction : tpv_widx

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode.

    logic apb_wr;      // A write lands at this edge.
    logic mapped;      // The address names a register.
    logic ctrl_wr;     // Write to the control strobes.
    logic end_instr;   // End of instruction.
    logic rti_req;     // Return from interrupt.
    logic jsr_req;     // Coroutine call.
    logic resume_req;  // Leave console debug mode.

    assign apb_wr  = psel_in & penable_in & pwrite_in & pready_out;
    assign mapped  = (paddr_in <= tpv_pkg::TPV_MEMDAT_OFF) && (paddr_in[1:0] == 2'b00);
    assign ctrl_wr = apb_wr && (paddr_in == tpv_pkg::TPV_CTRL_OFF);
    assign end_instr  = ctrl_wr & pwdata_in[tpv_pkg::TPV_CTRL_END_BIT];
    assign rti_req    = ctrl_wr & pwdata_in[tpv_pkg::TPV_CTRL_RTI_BIT];
    assign jsr_req    = ctrl_wr & pwdata_in[tpv_pkg::TPV_CTRL_JSR_BIT];
    assign resume_req = ctrl_wr & pwdata_in[tpv_pkg::TPV_CTRL_RESUME_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Arbitration.

    logic [9:0]  pending;
    logic [9:0]  grant;
    logic        any;
    logic [15:0] arb_vec;
    logic        abort_any;
    // Level four lands in bit 9 and level seven in bit 6.
    assign pending   = {s_irq[3], s_irq[2], s_irq[1], s_irq[0], trap_pend_q} & 10'h3FF;
    assign abort_any = |trap_pend_q[2:0];

    // Same ordering as the software view.
    tpv_arbiter u_arb (
        .pending_in  (pending),
        .priority_in (psw_q[tpv_pkg::TPV_PSW_PRI_LO +: 3]),
        .irq_vec7_in (irq_vector_in),
        .irq_vec6_in (irq_vector_in),
        .irq_vec5_in (irq_vector_in),
        .irq_vec4_in (irq_vector_in),
        .any_out     (any),
        .grant_out   (grant),
        .vector_out  (arb_vec)
    );

    // Aborts go at once; the rest wait for the end strobe.
    logic take;  // Start a service round this cycle.
    assign take = (state_q == tpv_pkg::TPV_IDLE) && (abort_any || (end_instr && any));

    // Trap latches: aborts capture at once, trace is sampled at the end strobe, power loss and stack limit whenever seen.
    // A newly arriving condition beats the clear of a granted one.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trap_pend_q <= 6'h00;
        end else begin
            logic [5:0] nxt;
            logic [5:0] setv;
            nxt  = trap_pend_q;
            setv = 6'h00;
            // One abort accepted at a time, highest first, so the set stays exclusive.
            if (!abort_any) begin
                if (s_map)      setv[tpv_pkg::TPV_C_MAP]     = 1'b1;
                else if (s_tmo) setv[tpv_pkg::TPV_C_TIMEOUT] = 1'b1;
                else if (s_par) setv[tpv_pkg::TPV_C_PARITY]  = 1'b1;
            end

            if (power_last_q && !s_pwr) setv[tpv_pkg::TPV_C_POWER] = 1'b1;
            if (sp_q < tpv_pkg::TPV_STACK_LIMIT) setv[tpv_pkg::TPV_C_STACK] = 1'b1;
            if (end_instr && psw_q[tpv_pkg::TPV_PSW_TRACE_BIT]) setv[tpv_pkg::TPV_C_TRACE] = 1'b1;

            if (take) nxt = nxt & ~grant[5:0];
            trap_pend_q <= nxt | setv;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Service sequencer with stack traffic.

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q     <= tpv_pkg::TPV_IDLE;
            psw_q       <= tpv_pkg::TPV_PSW_RESET;
            sp_q        <= tpv_pkg::TPV_SP_RESET;
            pc_q        <= tpv_pkg::TPV_PC_RESET;
            tmp_q       <= 16'h0000;
            vector_q    <= 16'h0000;
            irq_ack_out <= 4'h0;
        end else begin
            irq_ack_out <= 4'h0;
            unique case (state_q)
                tpv_pkg::TPV_IDLE: begin
                    if (take) begin
                        tmp_q       <= arb_vec;
                        vector_q    <= arb_vec;
                        irq_ack_out <= {grant[6], grant[7], grant[8], grant[9]};
                        state_q     <= tpv_pkg::TPV_PUSH_PSW;
                    end else if (rti_req) begin
                        state_q <= tpv_pkg::TPV_RTI_PC;
                    end else if (jsr_req) begin
                        state_q <= tpv_pkg::TPV_JSR_POP;
                    end else if (apb_wr && paddr_in == tpv_pkg::TPV_PSW_OFF) begin
                        psw_q <= pwdata_in[15:0];
                    end else if (apb_wr && paddr_in == tpv_pkg::TPV_SP_OFF) begin
                        sp_q <= pwdata_in[15:0];
                    end else if (apb_wr && paddr_in == tpv_pkg::TPV_PC_OFF) begin
                        pc_q <= pwdata_in[15:0];
                    end
                end

                tpv_pkg::TPV_PUSH_PSW: begin
                    sp_q    <= sp_q - 16'd2;
                    state_q <= tpv_pkg::TPV_PUSH_PC;
                end

                tpv_pkg::TPV_PUSH_PC: begin
                    sp_q    <= sp_q - 16'd2;
                    state_q <= tpv_pkg::TPV_LOAD_PC;
                end

                tpv_pkg::TPV_LOAD_PC: begin
                    pc_q    <= mem_q[tpv_widx(tmp_q)];
                    state_q <= tpv_pkg::TPV_LOAD_PSW;
                end

                tpv_pkg::TPV_LOAD_PSW: begin
                    psw_q   <= mem_q[tpv_widx(tmp_q + 16'd2)];
                    state_q <= s_halt ? tpv_pkg::TPV_DEBUG : tpv_pkg::TPV_IDLE;
                end

                tpv_pkg::TPV_DEBUG: begin
                    if (resume_req) state_q <= tpv_pkg::TPV_IDLE;
                end

                tpv_pkg::TPV_RTI_PC: begin
                    pc_q    <= mem_q[tpv_widx(sp_q)];
                    sp_q    <= sp_q + 16'd2;
                    state_q <= tpv_pkg::TPV_RTI_PSW;
                end

                tpv_pkg::TPV_RTI_PSW: begin
                    psw_q   <= mem_q[tpv_widx(sp_q)];
                    sp_q    <= sp_q + 16'd2;
                    state_q <= tpv_pkg::TPV_IDLE;
                end

                tpv_pkg::TPV_JSR_POP: begin
                    tmp_q   <= mem_q[tpv_widx(sp_q)];
                    sp_q    <= sp_q + 16'd2;
                    state_q <= tpv_pkg::TPV_JSR_PUSH;
                end

                tpv_pkg::TPV_JSR_PUSH: begin
                    sp_q    <= sp_q - 16'd2;
                    pc_q    <= tmp_q;
                    state_q <= tpv_pkg::TPV_IDLE;
                end
                default: state_q <= tpv_pkg::TPV_IDLE;
            endcase
        end
    end

    // Memory writes: stack pushes from the sequencer, otherwise the APB window.
    // No reset here: vectors are written before any trap.
    always_ff @(posedge clock_in) begin
        if (state_q == tpv_pkg::TPV_PUSH_PSW) begin
            mem_q[tpv_widx(sp_q - 16'd2)] <= psw_q;
        end else if (state_q == tpv_pkg::TPV_PUSH_PC) begin
            mem_q[tpv_widx(sp_q - 16'd2)] <= pc_q;
        end else if (state_q == tpv_pkg::TPV_JSR_PUSH) begin
            mem_q[tpv_widx(sp_q - 16'd2)] <= pc_q;
        end else if (apb_wr && paddr_in == tpv_pkg::TPV_MEMDAT_OFF) begin
            mem_q[memadr_q] <= pwdata_in[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status, mask, window address and interrupt output.

    logic [2:0] st_set;
    assign st_set = {(state_q == tpv_pkg::TPV_LOAD_PSW) && s_halt,
                     (s_map & s_tmo) | (s_map & s_par) | (s_tmo & s_par) | (s_ctl & (s_map | s_tmo | s_par)),
                     take};

    // Set wins over the write-one clear so no event is lost.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_q <= 3'h0;
            mask_q   <= 3'h0;
            memadr_q <= 8'h00;
        end else begin
            if (apb_wr && paddr_in == tpv_pkg::TPV_STATUS_OFF) begin
                status_q <= (status_q & ~pwdata_in[2:0]) | st_set;
            end else begin
                status_q <= status_q | st_set;
            end

            if (apb_wr && paddr_in == tpv_pkg::TPV_MASK_OFF) mask_q <= pwdata_in[2:0];
            if (apb_wr && paddr_in == tpv_pkg::TPV_MEMADR_OFF) memadr_q <= pwdata_in[7:0];
        end
    end

    // Registered outputs and read data. Access phase answers with one wait state.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out             <= 32'h0000_0000;
            pready_out             <= 1'b0;
            pslverr_out            <= 1'b0;
            service_state_out      <= 1'b0;
            console_debug_mode_out <= 1'b0;
            irq_out                <= 1'b0;
        end else begin
            pready_out  <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
            // Captured in the wait state so it stands with ready.
            if (psel_in & penable_in & ~pready_out) begin
                unique case (paddr_in)
                    tpv_pkg::TPV_STATUS_OFF: prdata_out <= {29'h0, status_q};
                    tpv_pkg::TPV_MASK_OFF:   prdata_out <= {29'h0, mask_q};
                    tpv_pkg::TPV_PSW_OFF:    prdata_out <= {16'h0, psw_q};
                    tpv_pkg::TPV_SP_OFF:     prdata_out <= {16'h0, sp_q};
                    tpv_pkg::TPV_PC_OFF:     prdata_out <= {16'h0, pc_q};
                    tpv_pkg::TPV_VECTOR_OFF: prdata_out <= {16'h0, vector_q};
                    tpv_pkg::TPV_PEND_OFF:   prdata_out <= {22'h0, pending};
                    tpv_pkg::TPV_MEMADR_OFF: prdata_out <= {24'h0, memadr_q};
                    tpv_pkg::TPV_MEMDAT_OFF: prdata_out <= {16'h0, mem_q[memadr_q]};
                    default:                 prdata_out <= 32'h0000_0000;
                endcase
            end

            service_state_out      <= (state_q != tpv_pkg::TPV_IDLE) && (state_q != tpv_pkg::TPV_DEBUG);
            console_debug_mode_out <= (state_q == tpv_pkg::TPV_DEBUG);
            irq_out                <= |(status_q & mask_q);
        end
    end

endmodule : tpv_top

// [tb/tpv_bus_model.sv]
// Bus devices that raise interrupt requests.
`timescale 1ns/100ps
module tpv_bus_model (
    input  wire logic       clock_in, rstn_in,
    input  wire logic [3:0] raise_in, ack_in,
    output logic [3:0]      irq_out
);
    // A request stays up until its own level is acknowledged.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) irq_out <= 4'h0;
        else irq_out <= (irq_out & ~ack_in) | raise_in;
    end
endmodule : tpv_bus_model

// [tb/tpv_monitor.sv]
// Port checker for the trap unit.
`timescale 1ns/100ps
module tpv_monitor (
    input wire logic       clock_in, rstn_in, psel_in, penable_in, pready_out,
    input wire logic       pslverr_out, service_state_out, console_debug_mode_out,
    input wire logic [7:0] paddr_in,
    input wire logic [3:0] irq_ack_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // Entry is four sequencer steps, then the unit leaves the service state.
    sequence s_entry; service_state_out [*4] ##1 !service_state_out; endsequence
    AST_ONE_ACK: assert property ($onehot0(irq_ack_out)) else $error("two levels acknowledged");
    AST_ENTRY_LEN: assert property ($rose(service_state_out) |-> s_entry) else $error("bad entry length");
    AST_DEBUG_CAUSE: assert property ($rose(console_debug_mode_out) |-> $past(service_state_out))
        else $error("debug mode outside service");
    AST_DEBUG_EXCL: assert property (console_debug_mode_out |-> !service_state_out) else $error("debug in entry");
    AST_READY_PULSE: assert property (pready_out |=> !pready_out) else $error("ready too long");
    AST_READY_CAUSE: assert property (pready_out |-> $past(psel_in && penable_in)) else $error("ready uncaused");
    AST_ERR_READY: assert property (pslverr_out |-> pready_out) else $error("error without ready");
    AST_ERR_ADDR: assert property (pready_out && paddr_in > 8'h24 |-> pslverr_out) else $error("unmapped accepted");
endmodule : tpv_monitor
bind tpv_top tpv_monitor u_mon (.clock_in, .rstn_in, .psel_in, .penable_in, .pready_out, .pslverr_out,
    .service_state_out, .console_debug_mode_out, .paddr_in, .irq_ack_out);

// [tb/tpv_top_tb.sv]
// Register level tests of the trap unit.
`timescale 1ns/100ps
module tpv_top_tb;
    logic clock_in, rstn_in, psel, pen, pwr, map, pgood, pready_out, svc, irq, halt, dbg;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] raise, ack, lvl;
    int num_errors, compares, cycles;
    tpv_top u_dut (.clock_in, .rstn_in, .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out, .pslverr_out(), .mapping_violation_flag_in(map),
        .bus_timeout_flag_in(1'b0), .bus_parity_flag_in(1'b0), .control_fault_flag_in(1'b0),
        .power_good_in(pgood), .irq_level_seven_in(lvl[3]), .irq_level_six_in(lvl[2]),
        .irq_level_five_in(lvl[1]), .irq_level_four_in(lvl[0]), .irq_vector_in(16'h0040),
        .halt_request_in(halt), .irq_ack_out(ack), .service_state_out(svc), .console_debug_mode_out(dbg),
        .irq_out(irq));
    tpv_bus_model u_dev (.clock_in, .rstn_in, .raise_in(raise), .ack_in(ack), .irq_out(lvl));
    initial begin clock_in = 0; forever #25 clock_in = ~clock_in; end
    // One APB transfer, held until ready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in); psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clock_in); pen <= 1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        q = prdata; psel <= 0; pen <= 0;
    endtask : apb
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0); compares++;
        if (q !== e) begin $display("unexpected reg %h exp %h got %h", a, e, q); num_errors++; end
    endtask : chk
    task automatic mem(input logic [7:0] i, input logic [31:0] d, input logic w);
        apb(1, tpv_pkg::TPV_MEMADR_OFF, {24'h0, i});
        if (w) apb(1, tpv_pkg::TPV_MEMDAT_OFF, d); else chk(tpv_pkg::TPV_MEMDAT_OFF, d);
    endtask : mem
    task automatic entry(); wait (svc === 1'b1); wait (svc === 1'b0); endtask : entry
    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // A hang is cut short well after the sequence should have ended.
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 6000) begin num_errors++; close_out(); end
    end
    initial begin
        {psel, pen, pwr, map, halt, raise, paddr, pwdata} = '0; pgood = 1; rstn_in = 0;
        repeat (3) @(posedge clock_in); rstn_in <= 1;
        chk(tpv_pkg::TPV_SP_OFF, 32'h0000_0200);
        mem(8'h54, 32'h0000_1234, 1); mem(8'h55, 32'h0000_00E0, 1); mem(8'h0A, 32'h0000_2000, 1);
        mem(8'h0B, 32'h0000_0000, 1); mem(8'h20, 32'h0000_0500, 1); mem(8'h21, 32'h0000_0080, 1);
        apb(1, tpv_pkg::TPV_MASK_OFF, 1); apb(1, tpv_pkg::TPV_PC_OFF, 32'h0000_0300);
        @(posedge clock_in); map <= 1; @(posedge clock_in); map <= 0;
        entry();
        chk(tpv_pkg::TPV_VECTOR_OFF, 32'h0000_00A8);
        chk(tpv_pkg::TPV_PC_OFF, 32'h0000_1234);
        chk(tpv_pkg::TPV_PSW_OFF, 32'h0000_00E0);
        chk(tpv_pkg::TPV_SP_OFF, 32'h0000_01FC);
        mem(8'hFE, 32'h0000_0300, 0);
        compares++; if (irq !== 1'b1) begin $display("unexpected irq exp 1 got %b", irq); num_errors++; end
        apb(1, tpv_pkg::TPV_STATUS_OFF, 1); repeat (3) @(posedge clock_in);
        compares++; if (irq !== 1'b0) begin $display("unexpected irq exp 0 got %b", irq); num_errors++; end
        @(posedge clock_in); raise <= 4'h1; @(posedge clock_in); raise <= 4'h0;
        apb(1, tpv_pkg::TPV_CTRL_OFF, 1); repeat (8) @(posedge clock_in);
        chk(tpv_pkg::TPV_PEND_OFF, 32'h0000_0200);
        apb(1, tpv_pkg::TPV_PSW_OFF, 0); apb(1, tpv_pkg::TPV_CTRL_OFF, 1); entry();
        chk(tpv_pkg::TPV_VECTOR_OFF, 32'h0000_0040);
        chk(tpv_pkg::TPV_PEND_OFF, 32'h0000_0000);
        @(posedge clock_in); pgood <= 0; repeat (4) @(posedge clock_in); pgood <= 1;
        halt <= 1; apb(1, tpv_pkg::TPV_CTRL_OFF, 1); entry();
        chk(tpv_pkg::TPV_VECTOR_OFF, 32'h0000_0014);
        chk(tpv_pkg::TPV_PC_OFF, 32'h0000_2000);
        compares++; if (dbg !== 1'b1) begin $display("unexpected dbg exp 1 got %b", dbg); num_errors++; end
        halt <= 0; apb(1, tpv_pkg::TPV_CTRL_OFF, 8); repeat (3) @(posedge clock_in);
        compares++; if (dbg !== 1'b0) begin $display("unexpected dbg exp 0 got %b", dbg); num_errors++; end
        apb(1, tpv_pkg::TPV_CTRL_OFF, 2); repeat (4) @(posedge clock_in);
        chk(tpv_pkg::TPV_PC_OFF, 32'h0000_0500);
        chk(tpv_pkg::TPV_PSW_OFF, 32'h0000_0080);
        apb(1, tpv_pkg::TPV_CTRL_OFF, 4); repeat (4) @(posedge clock_in);
        chk(tpv_pkg::TPV_PC_OFF, 32'h0000_1234);
        mem(8'hFC, 32'h0000_0500, 0);
        chk(8'h28, 32'h0000_0000);
        close_out();
    end
endmodule : tpv_top_tb
